// ---- design/psi_chan_if.sv ----
// per-pin configuration and result between top and indicator channel
interface psi_chan_if import psi_pkg::*; ();
   logic       tick;
   psi_mode_t  mode;
   logic [3:0] cycle;
   logic       stretch_en;
   logic       act;
   logic       steady;
   logic       train;
   logic       lit;
   modport top  (output tick, mode, cycle, stretch_en, act, steady, train, input lit);
   modport chan (input tick, mode, cycle, stretch_en, act, steady, train, output lit);
endinterface

// ---- design/psi_ind_chan.sv ----
// one indicator channel: activity stretch, blink timing and mode select
module psi_ind_chan
   import psi_pkg::*;
(
   input wire logic  i_core_clk,
   input wire logic  i_rstn,
   psi_chan_if.chan  ch
);
   // ==========================================================
   // activity stretch
   logic [5:0] str_cnt_reg;
   logic       act_eff;
   assign act_eff = ch.act | (ch.stretch_en & (str_cnt_reg != 6'h0)); // [RULE20]

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) str_cnt_reg <= 6'h0;
      else if (ch.act && ch.stretch_en) str_cnt_reg <= 6'(STRETCH_MS); // [RULE20]
      else if (ch.tick && str_cnt_reg != 6'h0) str_cnt_reg <= str_cnt_reg - 6'h1;
   end

   // ==========================================================
   // blink phase, half period of (cycle+1) units
   logic [3:0] unit_cnt_reg;
   logic [3:0] half_cnt_reg;
   logic       phase_reg;
   logic       unit_done;
   assign unit_done = ch.tick && (unit_cnt_reg == 4'(BLINK_UNIT_MS - 1));

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         unit_cnt_reg <= 4'h0;
         half_cnt_reg <= 4'h0;
         phase_reg    <= 1'b0;
      end else begin
         if (unit_done) unit_cnt_reg <= 4'h0;
         else if (ch.tick) unit_cnt_reg <= unit_cnt_reg + 4'h1;
         if (unit_done && half_cnt_reg >= ch.cycle) begin // [RULE7]
            half_cnt_reg <= 4'h0;
            phase_reg    <= ~phase_reg;
         end else if (unit_done) half_cnt_reg <= half_cnt_reg + 4'h1;
      end
   end

   // ==========================================================
   // mode select
   logic sel;
   logic lit_next;
   assign sel = ch.steady | act_eff; // [RULE3]
   assign lit_next = (ch.mode == MODE_BLINK)  ? ((sel | ch.train) & phase_reg) : // [RULE7]
                     (ch.mode == MODE_STEADY) ? (sel | (ch.train & phase_reg)) : // [RULE8]
                     1'b0; // [RULE6]

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) ch.lit <= 1'b0;
      else ch.lit <= lit_next;
   end

   // ==========================================================
   // checks
   AST_MODE_OFF: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [RULE6]
      (ch.mode == MODE_OFF) |=> !ch.lit) else $error("lit while mode off");
   AST_MASK_BLOCK: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [RULE2]
      (!ch.steady && !act_eff && !ch.train) |=> !ch.lit) else $error("lit with no source");
   AST_STEADY_ON: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [RULE8]
      (ch.mode == MODE_STEADY && ch.steady) |=> ch.lit) else $error("steady not lit");
   AST_STRETCH_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [RULE20]
      (ch.act && ch.stretch_en) ##1 (!ch.act) [*3] |-> act_eff)
      else $error("stretch dropped early");
   AST_BLINK_GATE: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [RULE7]
      (ch.mode == MODE_BLINK && $past(ch.mode) == MODE_BLINK && ch.lit)
      |-> $past(phase_reg)) else $error("blink lit in dark phase");
endmodule

// ---- design/psi_pkg.sv ----
// constants and types shared by the status indicator controller
package psi_pkg;
   // ==========================================================
   // timing
   localparam int CLK_MHZ       = 25;
   localparam int TICK_US       = 1000;
   localparam int TICK_CYCLES   = TICK_US * CLK_MHZ;
   localparam int BLINK_UNIT_MS = 10;
   localparam int STRETCH_MS    = 40;
   localparam int PRE_ONES      = 32;
   // ==========================================================
   // management frame fields
   localparam int         PINS      = 5;
   localparam int         PIN_LINK  = 3;
   localparam logic [4:0] DEVAD_PMA = 5'h01;
   localparam logic [1:0] OP_ADDR   = 2'h0;
   localparam logic [1:0] OP_WRITE  = 2'h1;
   localparam logic [1:0] OP_RINC   = 2'h2;
   localparam logic [1:0] OP_READ   = 2'h3;
   // ==========================================================
   // register offsets
   localparam logic [15:0] OFF_CTRL  = 16'hA83B;
   localparam logic [15:0] OFF_SRC   = 16'hA83C;
   localparam logic [15:0] OFF_SRC2  = 16'hA83D;
   localparam logic [15:0] OFF_MASK  [PINS] = '{16'hA831, 16'hA832, 16'hA833, 16'hA835, 16'hA836};
   localparam logic [15:0] OFF_MASK2 [PINS] = '{16'hA841, 16'hA842, 16'hA843, 16'hA844, 16'hA845};
   localparam logic [15:0] OFF_CFG   [PINS] = '{16'hA851, 16'hA852, 16'hA853, 16'hA854, 16'hA855};
   // ==========================================================
   // reset values and field layout
   localparam logic [14:0] CTRL_RST   = 15'h2452;
   localparam logic [14:0] CTRL_STRAP = 15'h4524;
   localparam logic [7:0]  MASK_RST  [PINS] = '{8'h08, 8'h10, 8'h06, 8'h40, 8'h80};
   localparam logic [5:0]  MASK2_RST [PINS] = '{6'h10, 6'h2C, 6'h00, 6'h00, 6'h0C};
   localparam logic [4:0]  CFG_RST   [PINS] = '{5'h03, 5'h03, 5'h13, 5'h03, 5'h03};
   localparam int          CTRL_W     = 3;
   localparam int          CTRL_OE    = 2;
   localparam int          CFG_STR    = 4;
   localparam int          SRC_ONE    = 5;
   localparam int          SRC_SPD_LO = 3;
   localparam int          SRC_SPD_HI = 4;
   localparam int          SRC2_TRAIN = 5;
   localparam logic [7:0]  SRC_ACT    = 8'h06;
   localparam logic [5:0]  SRC2_VIS   = 6'h0C;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      MODE_OFF = 2'h0, MODE_BLINK = 2'h1, MODE_STEADY = 2'h2, MODE_RSV = 2'h3
   } psi_mode_t;
   typedef enum logic [3:0] {
      ST_PRE = 4'h1, ST_HDR = 4'h2, ST_TA = 4'h4, ST_DATA = 4'h8
   } psi_mst_t;
endpackage

// ---- design/psi_top.sv ----
// status indicator controller with management frame register access
// Function
// [RULE1] five indicator pins, each configured independently by registers
// [RULE2] a source reaches a pin only where its mask bit is one
// [RULE3] several unmasked sources on one pin are ORed together
// [RULE4] live source register drives the pins through each pin's mask
// [RULE5] each pin has an active-low output enable bit
// [RULE6] mode 00 holds the indicator off
// [RULE7] mode 01 blinks while selected, period from four-bit cycle field
// [RULE8] mode 10 is steady on while selected; 11 is reserved
// [RULE9] source bit 1 is receive activity, bit 2 transmit activity
// [RULE10] software sets stretch enable on activity pins
// [RULE11] source bits 4:3 give 11 for gigabit, 10 for 100M link
// [RULE12] source bit 5 always reads one
// [RULE13] source bit 7 shows the 10G copper link up
// [RULE14] second source: bit 2 is 2.5G link, bit 3 is 5G link
// [RULE15] pin four mask starts at 0x0040 whatever the strap says
// [RULE16] software changes the control word by read-modify-write
// [RULE17] same registers govern the pins at every link rate
// [RULE18] strap low defaults at multi-gig rates: master, training, traffic, links
// [RULE19] strap low defaults at low speed: speed pair, traffic, link, pin5 unused
// [RULE20] stretcher holds activity a fixed tens of milliseconds after last pulse
// [RULE21] software frames use the port address and a 32-one preamble
module psi_top
   import psi_pkg::*;
#(
   parameter int P_TICK_CYCLES = TICK_CYCLES
)(
   input  wire logic        i_core_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_mdc,
   input  wire logic        i_mdio,
   output logic             o_mdio,
   output logic             o_mdio_oe_n,
   input  wire logic [4:0]  i_prtad,
   input  wire logic        i_cfg_strap,
   input  wire logic        i_rx_activity,
   input  wire logic        i_tx_activity,
   input  wire logic        i_link_100m,
   input  wire logic        i_link_1g,
   input  wire logic        i_link_2p5g,
   input  wire logic        i_link_5g,
   input  wire logic        i_link_10g,
   input  wire logic        i_master,
   input  wire logic        i_training,
   output logic [PINS-1:0]  o_indicator_pin_n,
   output logic [PINS-1:0]  o_indicator_output_enable_n
);
   // ==========================================================
   // pin synchronisers and start-up capture
   logic       mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
   logic       strap_s1, strap_s2;
   logic [4:0] prt_s1, prt_s2, port_reg;
   logic [1:0] init_cnt_reg;
   logic       init_done_reg;
   logic       init_load;
   logic       rise;
   assign init_load = !init_done_reg && (init_cnt_reg == 2'h3);
   assign rise      = mdc_s2 & ~mdc_s3;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         {mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2} <= 5'h1F;
         {strap_s1, strap_s2} <= 2'h0;
         {prt_s1, prt_s2}     <= 10'h0;
      end else begin
         {mdc_s1, mdc_s2, mdc_s3} <= {i_mdc, mdc_s1, mdc_s2};
         {mdio_s1, mdio_s2}       <= {i_mdio, mdio_s1};
         {strap_s1, strap_s2}     <= {i_cfg_strap, strap_s1};
         {prt_s1, prt_s2}         <= {i_prtad, prt_s1};
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         init_cnt_reg  <= 2'h0;
         init_done_reg <= 1'b0;
         port_reg      <= 5'h0;
      end else if (!init_done_reg) begin
         init_cnt_reg <= init_cnt_reg + 2'h1;
         if (init_load) begin
            init_done_reg <= 1'b1;
            port_reg      <= prt_s2;
         end
      end
   end

   // ==========================================================
   // millisecond tick
   logic [15:0] tick_cnt_reg;
   logic        tick_reg;
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tick_cnt_reg <= 16'h0;
         tick_reg     <= 1'b0;
      end else begin
         tick_reg     <= (tick_cnt_reg == 16'(P_TICK_CYCLES - 1));
         tick_cnt_reg <= (tick_cnt_reg == 16'(P_TICK_CYCLES - 1)) ? 16'h0 : tick_cnt_reg + 16'h1;
      end
   end

   // ==========================================================
   // live status sources
   logic [7:0] src_reg;
   logic [5:0] src2_reg;
   logic       mg_link, any_link;
   assign mg_link  = i_link_10g | i_link_5g | i_link_2p5g;
   assign any_link = mg_link | i_link_1g | i_link_100m;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         src_reg  <= 8'h20;
         src2_reg <= 6'h0;
      end else begin
         src_reg  <= {i_link_10g, any_link, 1'b1, // [RULE13] [RULE12] [RULE15]
                      i_link_1g | i_link_100m, i_link_1g, // [RULE11]
                      i_tx_activity, i_rx_activity, 1'b0}; // [RULE9]
         src2_reg <= {i_training, i_master & mg_link, // [RULE18]
                      i_link_5g, i_link_2p5g, 2'h0}; // [RULE14]
      end
   end

   // ==========================================================
   // management frame receiver
   psi_mst_t    state_reg;
   logic [5:0]  ones_reg;
   logic [4:0]  cnt_reg;
   logic [13:0] hdr_reg;
   logic [15:0] dat_reg, rd_reg, addr_reg;
   logic [1:0]  op_reg;
   logic        hit_reg;
   logic [13:0] hdr_next;
   logic [15:0] dat_next, rd_data;
   logic        is_rd, wr_fire, rd_load;
   assign hdr_next = {hdr_reg[12:0], mdio_s2};
   assign dat_next = {dat_reg[14:0], mdio_s2};
   assign is_rd    = hit_reg && op_reg[1];
   assign rd_load  = rise && state_reg == ST_TA && cnt_reg == 5'h1 && is_rd;
   assign wr_fire  = rise && state_reg == ST_DATA && cnt_reg == 5'hF && hit_reg
                     && op_reg == OP_WRITE;

   function automatic logic at(input logic [15:0] off);
      return addr_reg == off;
   endfunction

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= ST_PRE;
         {ones_reg, cnt_reg, hdr_reg, dat_reg, op_reg, hit_reg} <= 44'h0;
      end else if (rise && init_done_reg) begin
         case (state_reg)
            ST_PRE: begin
               if (mdio_s2) ones_reg <= (ones_reg == 6'(PRE_ONES)) ? ones_reg : ones_reg + 6'h1;
               else if (ones_reg == 6'(PRE_ONES)) begin // [RULE21]
                  state_reg <= ST_HDR;
                  hdr_reg   <= hdr_next;
                  cnt_reg   <= 5'h1;
               end else ones_reg <= 6'h0;
            end
            ST_HDR: begin
               hdr_reg <= hdr_next;
               cnt_reg <= cnt_reg + 5'h1;
               if (cnt_reg == 5'hD) begin
                  state_reg <= (hdr_next[13:12] == 2'h0) ? ST_TA : ST_PRE;
                  ones_reg  <= 6'h0;
                  cnt_reg   <= 5'h0;
                  op_reg    <= hdr_next[11:10];
                  hit_reg   <= hdr_next[9:5] == port_reg && hdr_next[4:0] == DEVAD_PMA;
               end
            end
            ST_TA: begin
               cnt_reg <= cnt_reg + 5'h1;
               if (cnt_reg == 5'h1) begin
                  state_reg <= ST_DATA;
                  cnt_reg   <= 5'h0;
               end
            end
            ST_DATA: begin
               dat_reg <= dat_next;
               cnt_reg <= cnt_reg + 5'h1;
               if (cnt_reg == 5'hF) state_reg <= ST_PRE;
            end
            default: state_reg <= ST_PRE;
         endcase
      end
   end

   // address pointer and read shifter
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         addr_reg    <= 16'h0;
         rd_reg      <= 16'h0;
         o_mdio      <= 1'b1;
         o_mdio_oe_n <= 1'b1;
      end else if (rise) begin
         if (state_reg == ST_TA && cnt_reg == 5'h0 && is_rd) begin
            o_mdio      <= 1'b0;
            o_mdio_oe_n <= 1'b0;
         end else if (rd_load) begin
            o_mdio <= rd_data[15];
            rd_reg <= {rd_data[14:0], 1'b0};
         end else if (state_reg == ST_DATA && cnt_reg == 5'hF) begin
            o_mdio      <= 1'b1;
            o_mdio_oe_n <= 1'b1;
            if (hit_reg && op_reg == OP_ADDR) addr_reg <= dat_next;
            if (hit_reg && op_reg == OP_RINC) addr_reg <= addr_reg + 16'h1;
         end else if (state_reg == ST_DATA && is_rd) begin
            o_mdio <= rd_reg[15];
            rd_reg <= {rd_reg[14:0], 1'b0};
         end
      end
   end

   // ==========================================================
   // register file
   logic [14:0] ctrl_reg;
   logic [7:0]  mask_reg  [PINS];
   logic [5:0]  mask2_reg [PINS];
   logic [4:0]  cfg_reg   [PINS];

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) ctrl_reg <= CTRL_RST; // [RULE18] [RULE19]
      else if (init_load && strap_s2) ctrl_reg <= CTRL_STRAP; // [RULE15]
      else if (wr_fire && at(OFF_CTRL)) ctrl_reg <= dat_next[14:0];
   end

   always_comb begin
      rd_data = 16'h0;
      if (at(OFF_CTRL)) rd_data = {1'b0, ctrl_reg};
      if (at(OFF_SRC)) rd_data = {8'h0, src_reg}; // [RULE4]
      if (at(OFF_SRC2)) rd_data = {10'h0, src2_reg & SRC2_VIS}; // [RULE14]
      for (int k = 0; k < PINS; k++) begin
         if (at(OFF_MASK[k])) rd_data = {8'h0, mask_reg[k]};
         if (at(OFF_MASK2[k])) rd_data = {10'h0, mask2_reg[k]};
         if (at(OFF_CFG[k])) rd_data = {11'h0, cfg_reg[k]};
      end
   end

   // ==========================================================
   // per-pin channels, one per indicator pin
   psi_chan_if ch_if [PINS] ();

   for (genvar k = 0; k < PINS; k++) begin : g_pin // [RULE1] [RULE17]
      logic strap_clr;
      assign strap_clr = init_load && strap_s2 && (k != PIN_LINK); // [RULE15]

      always_ff @(posedge i_core_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            mask_reg[k]  <= MASK_RST[k]; // [RULE18] [RULE19]
            mask2_reg[k] <= MASK2_RST[k];
            cfg_reg[k]   <= CFG_RST[k];
         end else if (strap_clr) begin
            mask_reg[k]  <= 8'h0;
            mask2_reg[k] <= 6'h0;
         end else if (wr_fire) begin
            if (at(OFF_MASK[k])) mask_reg[k] <= dat_next[7:0];
            if (at(OFF_MASK2[k])) mask2_reg[k] <= dat_next[5:0];
            if (at(OFF_CFG[k])) cfg_reg[k] <= dat_next[4:0];
         end
      end

      assign ch_if[k].tick       = tick_reg;
      assign ch_if[k].mode       = psi_mode_t'(ctrl_reg[k*CTRL_W +: 2]);
      assign ch_if[k].cycle      = cfg_reg[k][3:0];
      assign ch_if[k].stretch_en = cfg_reg[k][CFG_STR];
      assign ch_if[k].act        = |(mask_reg[k] & src_reg & SRC_ACT); // [RULE2] [RULE9]
      assign ch_if[k].steady     = |(mask_reg[k] & src_reg & ~SRC_ACT) // [RULE3] [RULE4]
                                   | |(mask2_reg[k][4:0] & src2_reg[4:0]);
      assign ch_if[k].train      = mask2_reg[k][SRC2_TRAIN] & src2_reg[SRC2_TRAIN];

      psi_ind_chan u_chan (
         .i_core_clk (i_core_clk),
         .i_rstn     (i_rstn),
         .ch         (ch_if[k])
      );

      always_ff @(posedge i_core_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            o_indicator_pin_n[k]           <= 1'b1;
            o_indicator_output_enable_n[k] <= 1'b1;
         end else begin
            o_indicator_pin_n[k]           <= ~ch_if[k].lit;
            o_indicator_output_enable_n[k] <= ctrl_reg[k*CTRL_W + CTRL_OE]; // [RULE5]
         end
      end

      AST_OE_MAP: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [RULE5]
         (ctrl_reg[k*CTRL_W + CTRL_OE] == 1'b0) [*2] |-> !o_indicator_output_enable_n[k])
         else $error("output enable not following control bit");
      AST_PIN_LIT: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [RULE3]
         ch_if[k].lit |=> !o_indicator_pin_n[k]) else $error("pin not lit");
   end

   // ==========================================================
   // checks
   AST_PIN4_INIT: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [RULE15]
      $rose(init_done_reg) |-> mask_reg[PIN_LINK] == MASK_RST[PIN_LINK]
         && ctrl_reg[PIN_LINK*CTRL_W +: CTRL_W] == CTRL_RST[PIN_LINK*CTRL_W +: CTRL_W])
      else $error("pin four mask not at link default");
   AST_SPEED_CODE: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [RULE11]
      (i_link_100m && !i_link_1g) |=> src_reg[SRC_SPD_HI:SRC_SPD_LO] == 2'h2)
      else $error("100M speed code wrong");
   AST_ALWAYS_ONE: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // [RULE12]
      (rd_load && at(OFF_SRC)) |-> rd_data[SRC_ONE]) else $error("constant source low");
endmodule

// ---- verif/phy_status_indicator_ctrl_bench.sv ----
// self-checking bench for the status indicator controller
module phy_status_indicator_ctrl_bench;
   import psi_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK  = 4;
   localparam int STR = STRETCH_MS * TK;
   // ==========================================================
   // signals
   logic        clk = 1'b0, rstn = 1'b0, mdc = 1'b0, md_en = 1'b0, md_v = 1'b1;
   logic        strap = 1'b0, rx = 1'b0, tx = 1'b0, l100 = 1'b0, l1g = 1'b0;
   logic        l2g = 1'b0, l5g = 1'b0, l10g = 1'b0, mst = 1'b0, trn = 1'b0, pv;
   logic [4:0]  prtad = 5'h00;
   wire         mdo, mdo_oe_n;
   wire [4:0]   pin_n, oe_n, lit;
   wire         mdio = !mdo_oe_n ? mdo : (md_en ? md_v : 1'b1);
   int          miscompares = 0;
   int          samples_checked = 0;
   int          n;
   logic [15:0] q, ctrl;
   logic [7:0]  r;
   logic [13:0] t;
   logic [13:0] tab [8] = '{
      {8'h20, 3'b010, 2'b00, 1'b1}, {8'h20, 3'b000, 2'b00, 1'b0},
      {8'h20, 3'b011, 2'b00, 1'b0}, {8'h00, 3'b010, 2'b00, 1'b0},
      {8'h82, 3'b010, 2'b10, 1'b1}, {8'h82, 3'b010, 2'b01, 1'b1},
      {8'h82, 3'b010, 2'b00, 1'b0}, {8'h20, 3'b110, 2'b00, 1'b0}};
   logic [4:0]  lk [4] = '{5'b10000, 5'b01000, 5'b00110, 5'b00001};
   logic [4:0]  ex [4] = '{5'b01011, 5'b01010, 5'b11001, 5'b11010};
   // ==========================================================
   // design and lamps
   psi_top #(.P_TICK_CYCLES(TK)) dut (
      .i_core_clk(clk), .i_rstn(rstn), .i_mdc(mdc), .i_mdio(mdio), .o_mdio(mdo),
      .o_mdio_oe_n(mdo_oe_n), .i_prtad(prtad), .i_cfg_strap(strap),
      .i_rx_activity(rx), .i_tx_activity(tx), .i_link_100m(l100), .i_link_1g(l1g),
      .i_link_2p5g(l2g), .i_link_5g(l5g), .i_link_10g(l10g), .i_master(mst),
      .i_training(trn), .o_indicator_pin_n(pin_n), .o_indicator_output_enable_n(oe_n));
   psi_led_model lamps (.i_pin_n(pin_n), .i_output_enable_n(oe_n), .o_lit(lit));
   // ==========================================================
   // tasks and expectations
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic mbit(input logic en, input logic v, output logic s);
      md_en <= en;
      md_v  <= v;
      repeat (4) @(posedge clk);
      mdc <= 1'b1;
      repeat (6) @(posedge clk);
      s = mdio;
      mdc <= 1'b0;
   endtask
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [15:0] d,
                        output logic [15:0] rq);
      logic        s;
      logic [17:0] sh;
      logic [63:0] w;
      w = {32'hFFFF_FFFF, 2'b00, op, pa, DEVAD_PMA, 2'b10, d};
      for (int i = 63; i >= 0; i--) begin
         mbit(!(op[1] && i < 18), w[i], s);
         sh = {sh[16:0], s};
      end
      @(posedge clk);
      md_en <= 1'b0;
      rq = sh[16:1];
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic [15:0] x;
      frame(OP_ADDR, prtad, a, x);
      frame(OP_WRITE, prtad, d, x);
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] rq);
      frame(OP_ADDR, prtad, a, rq);
      frame(OP_READ, prtad, 16'h0000, rq);
   endtask
   task automatic do_reset(input logic sv);
      rstn  <= 1'b0;
      strap <= sv;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
   function automatic logic [15:0] exp_src(input logic [7:0] v);
      return {8'h00, v[1], |v[5:1], 1'b1, v[4] | v[5], v[4], v[6], v[7], 1'b0};
   endfunction
   function automatic int half(input int c);
      return (c + 1) * BLINK_UNIT_MS * TK;
   endfunction
   // ==========================================================
   // watchdog and main sequence
   initial begin
      repeat (75000) @(posedge clk);
      miscompares++;
      test_done();
   end
   initial begin
      void'($urandom(38650));
      prtad <= 5'($urandom_range(31, 1));
      do_reset(1'b0);
      for (int c = 0; c < 4; c++) begin
         {l1g, l100, l10g, mst, l2g} <= lk[c];
         repeat (8) @(posedge clk);
         check({11'h0, lit & 5'b11011}, {11'h0, ex[c]});
      end
      {l1g, l100, l10g, mst, l2g, trn} <= 6'h01;
      repeat (8) @(posedge clk);
      n = 0;
      pv = lit[1];
      repeat (5 * half(int'(CFG_RST[1][3:0]))) begin
         @(posedge clk);
         if (lit[1] !== pv) n++;
         pv = lit[1];
      end
      check({15'h0, n >= 4 && n <= 6}, 16'h0001);
      trn <= 1'b0;
      rd(OFF_CTRL, q);
      check(q, {1'b0, CTRL_RST});
      for (int k = 0; k < PINS; k++) begin
         rd(OFF_MASK[k], q);
         check(q, {8'h00, MASK_RST[k]});
      end
      frame(OP_ADDR, prtad, OFF_MASK[0], q);
      frame(OP_RINC, prtad, 16'h0000, q);
      check(q, {8'h00, MASK_RST[0]});
      frame(OP_READ, prtad, 16'h0000, q);
      check(q, {8'h00, MASK_RST[1]});
      frame(OP_ADDR, prtad ^ 5'h01, OFF_CTRL, q);
      frame(OP_READ, prtad ^ 5'h01, 16'h0000, q);
      check(q, 16'hFFFF);
      rd(16'hA900, q);
      check(q, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         r = 8'($urandom);
         r[5] = r[5] & ~r[4];
         {rx, tx, l100, l1g, l2g, l5g, l10g, mst} <= r;
         if (i == 0) wr(OFF_SRC, 16'hFFFF);
         rd(OFF_SRC, q);
         check(q, exp_src(r));
         rd(OFF_SRC2, q);
         check(q, {12'h0, r[2], r[3], 2'b00});
      end
      {rx, tx, l100, l1g, l2g, l5g, l10g, mst} <= 8'h00;
      wr(OFF_MASK2[0], 16'h0000);
      wr(OFF_CFG[0], 16'h0000);
      for (int i = 0; i < 8; i++) begin
         t = tab[i];
         {rx, l10g} <= t[2:1];
         wr(OFF_MASK[0], {8'h00, t[13:6]});
         ctrl = {1'b0, CTRL_RST};
         ctrl[2:0] = t[5:3];
         wr(OFF_CTRL, ctrl);
         repeat (8) @(posedge clk);
         check({14'h0, oe_n[0], lit[0]}, {14'h0, t[5], t[0]});
      end
      {rx, l10g} <= 2'b00;
      wr(OFF_MASK[0], 16'h0020);
      rd(OFF_CTRL, ctrl);
      ctrl[2:0] = 3'b001;
      wr(OFF_CTRL, ctrl);
      for (int c = 0; c < 3; c += 2) begin
         wr(OFF_CFG[0], 16'(c));
         repeat (2 * half(c)) @(posedge clk);
         n = 0;
         pv = lit[0];
         repeat (8 * half(c)) begin
            @(posedge clk);
            if (lit[0] !== pv) n++;
            pv = lit[0];
         end
         check({15'h0, n >= 7 && n <= 9}, 16'h0001);
      end
      ctrl[2:0] = 3'b010;
      wr(OFF_CTRL, ctrl);
      wr(OFF_MASK[0], 16'h0002);
      for (int s = 1; s >= 0; s--) begin
         wr(OFF_CFG[0], {11'h0, 1'(s), 4'h0});
         rx <= 1'b1;
         @(posedge clk);
         rx <= 1'b0;
         repeat (STR - 20) @(posedge clk);
         check({15'h0, lit[0]}, 16'(s));
         repeat (40) @(posedge clk);
         check({15'h0, lit[0]}, 16'h0000);
      end
      do_reset(1'b1);
      rd(OFF_CTRL, q);
      check(q, {1'b0, CTRL_STRAP});
      rd(OFF_MASK[3], q);
      check(q, 16'h0040);
      test_done();
   end
endmodule

// ---- verif/psi_led_model.sv ----
// indicator lamps hanging on the controller's pins
module psi_led_model
   import psi_pkg::*;
(
   input  wire logic [PINS-1:0] i_pin_n,
   input  wire logic [PINS-1:0] i_output_enable_n,
   output logic      [PINS-1:0] o_lit
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // a lamp glows only while its driver is on and pulls low
   assign o_lit = ~i_output_enable_n & ~i_pin_n;
endmodule
